//--- pmc_pkg.sv
// package for the power-line mac control packet codec
//
// What this block does
// - terminal uplink request: dir/neg/ack 0; base never replies
// - switch modulation request: base replies positive or negative
// - base records uplink requester as promoted with new ident
// - downlink request: dir 1, neg 0, ack 0, ident below 0xFF
// - positive reply: neg 0, ack 1, ident below 0xFF
// - negative reply: neg 1, ack 1, ident below 0xFF, modulation only
// - service demotion: dir 0, neg 1, ack 0, ident below 0xFF
// - base demotion: dir 1, neg 1, ack 0
// - layout update (type 5) from base only, relayed by switches
// - layout leading 2-bit reserved field is 0b10
// - 2-bit layout length applies from next superframe
// - legacy phy flag selects backward-compatible type B frames
// - layout 1-bit and 3-bit reserved fields are zero
// - 5-bit sequence names the beacon where layout applies
// - type 6 allocates dedicated slot time to one node
// - slot meaning decoded from direction bit and type
// - slot packet: accept 1, direction 1, sequence 5, connection 9
// - slot packet: length 7, offset 9, type 2, target node 14
// - slot type 0 request/grant, 1 dealloc, 2 downlink relocate
package pmc_pkg;
  localparam logic [2:0] PMC_CTYPE_ROLE = 3'h4;
  localparam logic [2:0] PMC_CTYPE_LAYOUT = 3'h5;
  localparam logic [2:0] PMC_CTYPE_SLOT = 3'h6;
  localparam logic [7:0] PMC_IDENT_LIMIT = 8'hFF;
  localparam logic [1:0] PMC_LAYOUT_RES_HI = 2'h2;
  localparam int PMC_LAYOUT_BITS = 24;
  localparam int PMC_SLOT_BITS = 48;
  localparam logic [1:0] PMC_SLOT_ALLOC = 2'h0;
  localparam logic [1:0] PMC_SLOT_DEALLOC = 2'h1;
  localparam logic [1:0] PMC_SLOT_CHANGE = 2'h2;

  // role message classes
  typedef enum logic [2:0] {
    PMC_ROLE_NONE,
    PMC_ROLE_REQUEST_UPLINK,
    PMC_ROLE_REQUEST_DOWNLINK,
    PMC_ROLE_POSITIVE_REPLY,
    PMC_ROLE_NEGATIVE_REPLY,
    PMC_DEMOTION_UPLINK,
    PMC_DEMOTION_DOWNLINK
  } pmc_role_kind_t;

  // slot message classes
  typedef enum logic [2:0] {
    PMC_SLOT_NONE,
    PMC_SLOT_ALLOC_REQ,
    PMC_SLOT_ALLOC_GRANT,
    PMC_SLOT_ALLOC_REJECT,
    PMC_SLOT_DEALLOC_REQ,
    PMC_SLOT_DEALLOC_CONFIRM,
    PMC_SLOT_RELOCATE
  } pmc_slot_kind_t;
endpackage : pmc_pkg

//--- pmc_layout_rx.sv
// layout update packet field unpacker and reserved-field checker
`timescale 1ns/1ps
module pmc_layout_rx
  import pmc_pkg::*;
(
  input wire logic [23:0] pkt_i,
  output logic ok_o,
  output logic [1:0] len_o,
  output logic flag_o,
  output logic [9:0] cfp_o,
  output logic [4:0] seq_o
);
  // msb-first split; reserved must match exactly
  always_comb
  begin
    len_o = pkt_i[21:20];
    flag_o = pkt_i[19];
    cfp_o = pkt_i[17:8];
    seq_o = pkt_i[7:3];
    ok_o = (pkt_i[23:22] == PMC_LAYOUT_RES_HI) && !pkt_i[18] && (pkt_i[2:0] == 3'h0);
  end
endmodule : pmc_layout_rx

//--- pmc_codec.sv
// mac control packet codec: builds and classifies role, layout and slot packets
`timescale 1ns/1ps
module pmc_codec
  import pmc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic is_base_i,
  input wire logic is_switch_i,
  // role transmit request
  input wire logic role_tx_go_i,
  input wire logic [2:0] role_tx_kind_i,
  input wire logic [7:0] role_tx_ident_i,
  input wire logic role_tx_modulation_i,
  output logic role_tx_valid_o,
  output logic role_tx_dir_o,
  output logic role_tx_neg_o,
  output logic role_tx_ack_o,
  output logic [7:0] role_tx_ident_o,
  output logic role_tx_err_o,
  // role receive
  input wire logic role_rx_valid_i,
  input wire logic downlink_dir_bit_i,
  input wire logic role_negative_flag_i,
  input wire logic role_ack_flag_i,
  input wire logic [7:0] new_switch_ident_i,
  input wire logic [13:0] role_rx_node_i,
  input wire logic role_rx_from_switch_i,
  output logic role_rx_valid_o,
  output logic [2:0] role_rx_kind_o,
  output logic role_rx_reply_due_o,
  output logic promo_valid_o,
  output logic [13:0] promo_node_o,
  output logic [7:0] local_switch_ident_o,
  // layout update transmit and receive
  input wire logic layout_tx_go_i,
  input wire logic [1:0] layout_length_attribute_i,
  input wire logic legacy_phy_flag_i,
  input wire logic [9:0] reserved_period_length_i,
  input wire logic [4:0] layout_effective_seq_i,
  output logic layout_tx_valid_o,
  output logic [23:0] layout_update_packet_o,
  input wire logic layout_rx_valid_i,
  input wire logic [23:0] layout_rx_packet_i,
  output logic layout_relay_valid_o,
  output logic [23:0] layout_relay_packet_o,
  output logic layout_pending_o,
  output logic [1:0] next_layout_length_o,
  output logic legacy_phy_o,
  output logic [9:0] reserved_length_o,
  output logic [4:0] layout_seq_o,
  input wire logic beacon_valid_i,
  input wire logic [4:0] beacon_seq_i,
  output logic layout_apply_o,
  output logic layout_rx_bad_o,
  // slot packet transmit and receive
  input wire logic slot_tx_go_i,
  input wire logic slot_accept_flag_i,
  input wire logic slot_direction_i,
  input wire logic [4:0] slot_effective_seq_i,
  input wire logic [8:0] slot_connection_ident_i,
  input wire logic [6:0] slot_length_symbols_i,
  input wire logic [8:0] slot_offset_symbols_i,
  input wire logic [1:0] slot_msg_type_i,
  input wire logic [13:0] slot_target_node_i,
  output logic slot_tx_valid_o,
  output logic [47:0] dedicated_slot_packet_o,
  output logic slot_tx_err_o,
  input wire logic slot_rx_valid_i,
  input wire logic slot_rx_dir_i,
  input wire logic [47:0] slot_rx_packet_i,
  output logic slot_rx_valid_o,
  output logic [2:0] slot_rx_kind_o,
  output logic [8:0] slot_rx_conn_o,
  output logic [6:0] slot_rx_len_o,
  output logic [8:0] slot_rx_pos_o,
  output logic [4:0] slot_rx_seq_o,
  output logic [13:0] slot_rx_node_o
);
  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic role_tx_valid;
    logic role_tx_dir;
    logic role_tx_neg;
    logic role_tx_ack;
    logic [7:0] role_tx_ident;
    logic role_tx_err;
    logic role_rx_valid;
    logic [2:0] role_rx_kind;
    logic role_rx_reply_due;
    logic promo_valid;
    logic [13:0] promo_node;
    logic [7:0] local_ident;
    logic layout_tx_valid;
    logic [23:0] layout_tx_pkt;
    logic layout_relay_valid;
    logic [23:0] layout_relay_pkt;
    logic layout_pending;
    logic [1:0] lay_len;
    logic lay_legacy;
    logic [9:0] lay_cfp;
    logic [4:0] lay_seq;
    logic layout_apply;
    logic layout_rx_bad;
    logic slot_tx_valid;
    logic [47:0] slot_tx_pkt;
    logic slot_tx_err;
    logic slot_rx_valid;
    logic [2:0] slot_rx_kind;
    logic [8:0] slot_conn;
    logic [6:0] slot_len;
    logic [8:0] slot_pos;
    logic [4:0] slot_seq;
    logic [13:0] slot_node;
  } pmc_state_t;

  pmc_state_t s_q;
  pmc_state_t s_d;
  pmc_role_kind_t tx_kind;
  logic lay_ok;
  logic [1:0] lay_len_w;
  logic lay_flag_w;
  logic [9:0] lay_cfp_w;
  logic [4:0] lay_seq_w;

  assign tx_kind = pmc_role_kind_t'(role_tx_kind_i);

  //////////////////////////////////////////////////////////////////////////////
  // layout update unpacker
  pmc_layout_rx u_layout_rx (
    .pkt_i(layout_rx_packet_i),
    .ok_o(lay_ok),
    .len_o(lay_len_w),
    .flag_o(lay_flag_w),
    .cfp_o(lay_cfp_w),
    .seq_o(lay_seq_w)
  );

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic; every valid/error strobe lasts one cycle
  always_comb
  begin
    s_d = s_q;
    s_d.role_tx_valid = 1'b0;
    s_d.role_tx_err = 1'b0;
    s_d.role_rx_valid = 1'b0;
    s_d.promo_valid = 1'b0;
    s_d.layout_tx_valid = 1'b0;
    s_d.layout_relay_valid = 1'b0;
    s_d.layout_apply = 1'b0;
    s_d.layout_rx_bad = 1'b0;
    s_d.slot_tx_valid = 1'b0;
    s_d.slot_tx_err = 1'b0;
    s_d.slot_rx_valid = 1'b0;

    // role header build; ident 0xFF refused where limited
    if (role_tx_go_i)
    begin
      s_d.role_tx_ident = role_tx_ident_i;
      s_d.role_tx_valid = 1'b1;
      unique case (tx_kind)
        PMC_ROLE_REQUEST_UPLINK:
        begin
          {s_d.role_tx_dir, s_d.role_tx_neg, s_d.role_tx_ack} = 3'h0;
          s_d.role_tx_err = is_base_i;
        end
        PMC_ROLE_REQUEST_DOWNLINK:
        begin
          {s_d.role_tx_dir, s_d.role_tx_neg, s_d.role_tx_ack} = 3'h4;
          s_d.role_tx_err = !is_base_i || role_tx_ident_i == PMC_IDENT_LIMIT;
        end
        PMC_ROLE_POSITIVE_REPLY:
        begin
          {s_d.role_tx_dir, s_d.role_tx_neg, s_d.role_tx_ack} = {is_base_i, 2'h1};
          s_d.role_tx_err = role_tx_ident_i == PMC_IDENT_LIMIT;
        end
        PMC_ROLE_NEGATIVE_REPLY:
        begin
          {s_d.role_tx_dir, s_d.role_tx_neg, s_d.role_tx_ack} = {is_base_i, 2'h3};
          s_d.role_tx_err = role_tx_ident_i == PMC_IDENT_LIMIT || !role_tx_modulation_i;
        end
        PMC_DEMOTION_UPLINK:
        begin
          {s_d.role_tx_dir, s_d.role_tx_neg, s_d.role_tx_ack} = 3'h2;
          s_d.role_tx_err = is_base_i || role_tx_ident_i == PMC_IDENT_LIMIT;
        end
        PMC_DEMOTION_DOWNLINK:
        begin
          {s_d.role_tx_dir, s_d.role_tx_neg, s_d.role_tx_ack} = 3'h6;
          s_d.role_tx_err = !is_base_i;
        end
        default:
        begin
          s_d.role_tx_err = 1'b1;
        end
      endcase
      if (s_d.role_tx_err)
        s_d.role_tx_valid = 1'b0;
    end

    // role rx; ack set ignores direction
    if (role_rx_valid_i)
    begin
      s_d.role_rx_valid = 1'b1;
      s_d.role_rx_reply_due = 1'b0;
      unique case ({role_ack_flag_i, role_negative_flag_i, downlink_dir_bit_i})
        3'h0:
        begin
          s_d.role_rx_kind = PMC_ROLE_REQUEST_UPLINK;
          // terminal promotion is informational, modulation change is a procedure
          s_d.role_rx_reply_due = is_base_i && role_rx_from_switch_i;
          if (is_base_i)
          begin
            s_d.promo_valid = 1'b1;
            s_d.promo_node = role_rx_node_i;
            s_d.local_ident = new_switch_ident_i;
          end
        end
        3'h1: s_d.role_rx_kind = PMC_ROLE_REQUEST_DOWNLINK;
        3'h2: s_d.role_rx_kind = PMC_DEMOTION_UPLINK;
        3'h3: s_d.role_rx_kind = PMC_DEMOTION_DOWNLINK;
        3'h4, 3'h5: s_d.role_rx_kind = PMC_ROLE_POSITIVE_REPLY;
        default: s_d.role_rx_kind = PMC_ROLE_NEGATIVE_REPLY;
      endcase
      if ((role_ack_flag_i || role_negative_flag_i) && new_switch_ident_i == PMC_IDENT_LIMIT
          && s_d.role_rx_kind != PMC_DEMOTION_DOWNLINK)
      begin
        s_d.role_rx_kind = PMC_ROLE_NONE;
      end
    end

    // layout update build, base only
    if (layout_tx_go_i && is_base_i)
    begin
      s_d.layout_tx_valid = 1'b1;
      s_d.layout_tx_pkt = {PMC_LAYOUT_RES_HI, layout_length_attribute_i, legacy_phy_flag_i, 1'b0,
                           reserved_period_length_i, layout_effective_seq_i, 3'h0};
    end

    // layout rx: store, relay at switches
    if (layout_rx_valid_i && !is_base_i)
    begin
      if (lay_ok)
      begin
        s_d.layout_pending = 1'b1;
        s_d.lay_len = lay_len_w;
        s_d.lay_legacy = lay_flag_w;
        s_d.lay_cfp = lay_cfp_w;
        s_d.lay_seq = lay_seq_w;
        s_d.layout_relay_valid = is_switch_i;
        s_d.layout_relay_pkt = layout_rx_packet_i;
      end
      else
      begin
        s_d.layout_rx_bad = 1'b1;
      end
    end
    else if (beacon_valid_i && s_q.layout_pending && beacon_seq_i == s_q.lay_seq)
    begin
      s_d.layout_pending = 1'b0;
      s_d.layout_apply = 1'b1;
    end

    // slot packet build; relocation is base only
    if (slot_tx_go_i)
    begin
      s_d.slot_tx_pkt = {slot_accept_flag_i, slot_direction_i, slot_effective_seq_i, slot_connection_ident_i,
                         slot_length_symbols_i, slot_offset_symbols_i, slot_msg_type_i,
                         slot_target_node_i};
      s_d.slot_tx_err = slot_msg_type_i == 2'h3 || (!is_base_i && slot_msg_type_i == PMC_SLOT_CHANGE);
      s_d.slot_tx_valid = !s_d.slot_tx_err;
    end

    // slot classification by type and direction
    if (slot_rx_valid_i)
    begin
      s_d.slot_rx_valid = 1'b1;
      s_d.slot_conn = slot_rx_packet_i[40:32];
      s_d.slot_seq = slot_rx_packet_i[45:41];
      s_d.slot_len = slot_rx_packet_i[31:25];
      s_d.slot_pos = slot_rx_packet_i[24:16];
      s_d.slot_node = slot_rx_packet_i[13:0];
      unique case ({slot_rx_packet_i[15:14], slot_rx_dir_i})
        {PMC_SLOT_ALLOC, 1'b0}: s_d.slot_rx_kind = PMC_SLOT_ALLOC_REQ;
        {PMC_SLOT_ALLOC, 1'b1}:
          s_d.slot_rx_kind = slot_rx_packet_i[47] ? PMC_SLOT_ALLOC_GRANT : PMC_SLOT_ALLOC_REJECT;
        {PMC_SLOT_DEALLOC, 1'b0}: s_d.slot_rx_kind = PMC_SLOT_DEALLOC_REQ;
        {PMC_SLOT_DEALLOC, 1'b1}: s_d.slot_rx_kind = PMC_SLOT_DEALLOC_CONFIRM;
        {PMC_SLOT_CHANGE, 1'b1}: s_d.slot_rx_kind = PMC_SLOT_RELOCATE;
        default: s_d.slot_rx_kind = PMC_SLOT_NONE; // uplink change or type 3 carry no meaning
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register the whole state, synchronous reset
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign role_tx_valid_o = s_q.role_tx_valid;
  assign role_tx_dir_o = s_q.role_tx_dir;
  assign role_tx_neg_o = s_q.role_tx_neg;
  assign role_tx_ack_o = s_q.role_tx_ack;
  assign role_tx_ident_o = s_q.role_tx_ident;
  assign role_tx_err_o = s_q.role_tx_err;
  assign role_rx_valid_o = s_q.role_rx_valid;
  assign role_rx_kind_o = s_q.role_rx_kind;
  assign role_rx_reply_due_o = s_q.role_rx_reply_due;
  assign promo_valid_o = s_q.promo_valid;
  assign promo_node_o = s_q.promo_node;
  assign local_switch_ident_o = s_q.local_ident;
  assign layout_tx_valid_o = s_q.layout_tx_valid;
  assign layout_update_packet_o = s_q.layout_tx_pkt;
  assign layout_relay_valid_o = s_q.layout_relay_valid;
  assign layout_relay_packet_o = s_q.layout_relay_pkt;
  assign layout_pending_o = s_q.layout_pending;
  assign next_layout_length_o = s_q.lay_len;
  assign legacy_phy_o = s_q.lay_legacy;
  assign reserved_length_o = s_q.lay_cfp;
  assign layout_seq_o = s_q.lay_seq;
  assign layout_apply_o = s_q.layout_apply;
  assign layout_rx_bad_o = s_q.layout_rx_bad;
  assign slot_tx_valid_o = s_q.slot_tx_valid;
  assign dedicated_slot_packet_o = s_q.slot_tx_pkt;
  assign slot_tx_err_o = s_q.slot_tx_err;
  assign slot_rx_valid_o = s_q.slot_rx_valid;
  assign slot_rx_kind_o = s_q.slot_rx_kind;
  assign slot_rx_conn_o = s_q.slot_conn;
  assign slot_rx_len_o = s_q.slot_len;
  assign slot_rx_pos_o = s_q.slot_pos;
  assign slot_rx_seq_o = s_q.slot_seq;
  assign slot_rx_node_o = s_q.slot_node;
endmodule : pmc_codec

//--- pmc_codec_asserts.sv
// concurrent checks on the ports of the mac control packet codec
`timescale 1ns/1ps
module pmc_codec_chk
  import pmc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic is_base_i,
  input wire logic is_switch_i,
  input wire logic role_tx_go_i,
  input wire logic [2:0] role_tx_kind_i,
  input wire logic role_tx_valid_o,
  input wire logic role_tx_err_o,
  input wire logic role_tx_dir_o,
  input wire logic role_tx_neg_o,
  input wire logic role_tx_ack_o,
  input wire logic [7:0] role_tx_ident_o,
  input wire logic role_rx_valid_i,
  input wire logic promo_valid_o,
  input wire logic layout_tx_valid_o,
  input wire logic [23:0] layout_update_packet_o,
  input wire logic layout_rx_valid_i,
  input wire logic [23:0] layout_rx_packet_i,
  input wire logic layout_relay_valid_o,
  input wire logic [23:0] layout_relay_packet_o,
  input wire logic layout_rx_bad_o,
  input wire logic layout_pending_o,
  input wire logic [4:0] layout_seq_o,
  input wire logic beacon_valid_i,
  input wire logic [4:0] beacon_seq_i,
  input wire logic layout_apply_o,
  input wire logic slot_tx_go_i,
  input wire logic [1:0] slot_msg_type_i,
  input wire logic slot_tx_valid_o,
  input wire logic slot_tx_err_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////////////////
  // clean layout at a switch; beacon hitting the seq
  sequence s_good_layout;
    layout_rx_valid_i && is_switch_i && !is_base_i && layout_rx_packet_i[23:22] == PMC_LAYOUT_RES_HI
      && layout_rx_packet_i[18] == 1'b0 && layout_rx_packet_i[2:0] == 3'h0;
  endsequence
  sequence s_due_beacon;
    beacon_valid_i && layout_pending_o && beacon_seq_i == layout_seq_o && !layout_rx_valid_i;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // role tx: valid or err, never both
  a_role_tx_answer: assert property (role_tx_go_i |=> role_tx_valid_o != role_tx_err_o)
    else $error("role tx answer");
  a_dl_request_bits: assert property (role_tx_valid_o && $past(role_tx_kind_i) == 3'h2
    |-> role_tx_dir_o && !role_tx_neg_o && !role_tx_ack_o && role_tx_ident_o != PMC_IDENT_LIMIT)
    else $error("downlink flags");
  a_reply_bits: assert property (role_tx_valid_o && $past(role_tx_kind_i) inside {3'h3, 3'h4}
    |-> role_tx_ack_o && role_tx_ident_o != PMC_IDENT_LIMIT && (role_tx_neg_o == ($past(role_tx_kind_i) == 3'h4)))
    else $error("reply flags");
  a_promo_cause: assert property (promo_valid_o |-> $past(role_rx_valid_i) && $past(is_base_i))
    else $error("stray promotion");
  // layout: reserved values, base only, relay copy
  a_layout_reserved: assert property (layout_tx_valid_o |-> layout_update_packet_o[23:22] == 2'h2
    && layout_update_packet_o[18] == 1'b0 && layout_update_packet_o[2:0] == 3'h0)
    else $error("layout reserved");
  a_layout_base_only: assert property (layout_tx_valid_o |-> $past(is_base_i))
    else $error("layout from non-base");
  a_relay_copy: assert property (s_good_layout |=> layout_relay_valid_o ##0
    layout_relay_packet_o == $past(layout_rx_packet_i))
    else $error("no relay");
  a_bad_no_relay: assert property (layout_rx_bad_o |-> !layout_relay_valid_o && $past(layout_rx_valid_i))
    else $error("bad layout");
  a_apply_at_seq: assert property (s_due_beacon |=> layout_apply_o && !layout_pending_o)
    else $error("no apply");
  // slot transmit: undefined type is refused
  a_slot_type_err: assert property (slot_tx_go_i && slot_msg_type_i == 2'h3 |=> slot_tx_err_o && !slot_tx_valid_o)
    else $error("slot type 3");
endmodule : pmc_codec_chk

bind pmc_codec pmc_codec_chk i_pmc_codec_chk (.*);

//--- pmc_peer_node.sv
// peer base node model sending layout updates
`timescale 1ns/1ps
module pmc_peer_node
(
  input wire logic sys_clk_i,
  input wire logic send_i,
  input wire logic corrupt_i,
  input wire logic [1:0] len_i,
  input wire logic flag_i,
  input wire logic [9:0] cfp_i,
  input wire logic [4:0] seq_i,
  output logic layout_rx_valid_o,
  output logic [23:0] layout_rx_packet_o
);
  logic req_q;
  logic [23:0] pkt_q;
  ////////////////////////////////////////////////////////////////////////////
  // capture on rising edge; corrupt sets the 1-bit reserved
  always @(posedge sys_clk_i)
  begin
    req_q <= send_i;
    pkt_q <= {2'h2, len_i, flag_i, corrupt_i, cfp_i, seq_i, 3'h0};
  end
  // launch on falling edge; idle data toggles so stale bits never match
  always @(negedge sys_clk_i)
  begin
    layout_rx_valid_o <= req_q;
    layout_rx_packet_o <= req_q ? pkt_q : ~layout_rx_packet_o;
  end
  initial layout_rx_valid_o = 1'b0;
  initial layout_rx_packet_o = 24'h5A5A5A;
endmodule : pmc_peer_node

//--- pmc_codec_test.sv
// self-checking bench for the mac control packet codec
`timescale 1ns/1ps
module pmc_codec_test;
  import pmc_pkg::*;
  logic sys_clk_i, nrst_i, is_base_i, is_switch_i, role_tx_go_i, role_tx_modulation_i, role_tx_valid_o;
  logic role_tx_dir_o, role_tx_neg_o, role_tx_ack_o, role_tx_err_o, role_rx_valid_i, downlink_dir_bit_i;
  logic role_negative_flag_i, role_ack_flag_i, role_rx_from_switch_i, role_rx_valid_o, role_rx_reply_due_o;
  logic promo_valid_o, layout_tx_go_i, legacy_phy_flag_i, layout_tx_valid_o, layout_rx_valid_i;
  logic layout_relay_valid_o, layout_pending_o, legacy_phy_o, beacon_valid_i, layout_apply_o, layout_rx_bad_o;
  logic slot_tx_go_i, slot_accept_flag_i, slot_direction_i, slot_tx_valid_o, slot_tx_err_o, slot_rx_valid_i;
  logic slot_rx_dir_i, slot_rx_valid_o, pk_send, pk_bad;
  logic [1:0] layout_length_attribute_i, next_layout_length_o, slot_msg_type_i;
  logic [2:0] role_tx_kind_i, role_rx_kind_o, slot_rx_kind_o;
  logic [4:0] layout_effective_seq_i, layout_seq_o, beacon_seq_i, slot_effective_seq_i, slot_rx_seq_o;
  logic [6:0] slot_length_symbols_i, slot_rx_len_o;
  logic [7:0] role_tx_ident_i, role_tx_ident_o, new_switch_ident_i, local_switch_ident_o;
  logic [8:0] slot_connection_ident_i, slot_offset_symbols_i, slot_rx_conn_o, slot_rx_pos_o;
  logic [9:0] reserved_period_length_i, reserved_length_o;
  logic [13:0] role_rx_node_i, promo_node_o, slot_target_node_i, slot_rx_node_o;
  logic [23:0] layout_update_packet_o, layout_rx_packet_i, layout_relay_packet_o;
  logic [47:0] dedicated_slot_packet_o, slot_rx_packet_i;
  int n_errors = 0;
  int check_count = 0;
  pmc_codec i_pmc_codec (.*);
  pmc_peer_node i_pmc_peer_node (.sys_clk_i(sys_clk_i), .send_i(pk_send), .corrupt_i(pk_bad),
    .len_i(layout_length_attribute_i), .flag_i(legacy_phy_flag_i), .cfp_i(reserved_period_length_i),
    .seq_i(layout_effective_seq_i), .layout_rx_valid_o(layout_rx_valid_i), .layout_rx_packet_o(layout_rx_packet_i));
  ////////////////////////////////////////////////////////////////////////////
  // 50 ns clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  task automatic step();
    @(negedge sys_clk_i);
  endtask : step
  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  // one role tx; reply dir not checked
  task automatic role_tx(input logic b, input logic [2:0] k, input logic [7:0] id, input logic m, input logic e,
    input logic [2:0] dna);
    is_base_i = b; role_tx_kind_i = k; role_tx_ident_i = id; role_tx_modulation_i = m; role_tx_go_i = 1'b1;
    step();
    role_tx_go_i = 1'b0;
    chk(role_tx_err_o, e, "role tx err");
    chk(role_tx_valid_o, !e, "role tx valid");
    if (!e)
      chk({role_tx_neg_o, role_tx_ack_o, role_tx_ident_o}, {dna[1:0], id}, "role tx flags");
    if (!e && k != 3'h3 && k != 3'h4)
      chk(role_tx_dir_o, dna[2], "role tx dir");
    step();
  endtask : role_tx
  // one role rx at base
  task automatic role_rx(input logic sw, input logic [2:0] dna, input logic [7:0] id, input logic [2:0] k,
    input logic due);
    is_base_i = 1'b1; role_rx_from_switch_i = sw; {downlink_dir_bit_i, role_negative_flag_i, role_ack_flag_i} = dna;
    new_switch_ident_i = id; role_rx_node_i = {6'h15, id}; role_rx_valid_i = 1'b1;
    step();
    role_rx_valid_i = 1'b0;
    chk({role_rx_valid_o, role_rx_kind_o, role_rx_reply_due_o}, {1'b1, k, due}, "role rx class");
    chk(promo_valid_o, k == 3'h1, "promotion pulse");
    if (k == 3'h1)
      chk({promo_node_o, local_switch_ident_o}, {6'h15, id, id}, "promotion record");
    step();
  endtask : role_rx
  ////////////////////////////////////////////////////////////////////////////
  // base sends; switch relays, applies, refuses corrupt
  task automatic layout_test();
    layout_length_attribute_i = 2'h3; legacy_phy_flag_i = 1'b1; reserved_period_length_i = 10'h2A5;
    layout_effective_seq_i = 5'h11; is_base_i = 1'b1; layout_tx_go_i = 1'b1;
    step();
    layout_tx_go_i = 1'b0;
    chk({layout_tx_valid_o, layout_update_packet_o}, {1'b1, 24'hBAA588}, "layout packet");
    step();
    is_base_i = 1'b0; is_switch_i = 1'b1; layout_tx_go_i = 1'b1;
    step();
    layout_tx_go_i = 1'b0;
    chk(layout_tx_valid_o, 1'b0, "layout from non-base");
    for (int bad = 0; bad < 2; bad++)
    begin
      pk_bad = bad[0]; pk_send = 1'b1;
      step();
      pk_send = 1'b0;
      step();
      chk({layout_relay_valid_o, layout_rx_bad_o}, {!bad[0], bad[0]}, "relay or refuse");
    end
    chk({layout_relay_packet_o, layout_pending_o}, {24'hBAA588, 1'b1}, "relayed packet");
    chk({next_layout_length_o, legacy_phy_o, reserved_length_o, layout_seq_o}, {2'h3, 1'b1, 10'h2A5, 5'h11},
      "stored layout");
    for (int s = 16; s < 18; s++)
    begin
      beacon_valid_i = 1'b1; beacon_seq_i = s[4:0];
      step();
      beacon_valid_i = 1'b0;
      chk({layout_apply_o, layout_pending_o}, {s == 17, s != 17}, "apply at beacon");
      step();
    end
  endtask : layout_test
  ////////////////////////////////////////////////////////////////////////////
  // slot packets: send every type, decode every type and direction except type 3 with direction 1
  task automatic slot_test();
    logic [47:0] p;
    is_base_i = 1'b1; {slot_accept_flag_i, slot_direction_i, slot_effective_seq_i} = 7'h5B;
    slot_connection_ident_i = 9'h1A5; slot_length_symbols_i = 7'h55; slot_offset_symbols_i = 9'h0F3;
    slot_target_node_i = 14'h2ABC;
    for (int t = 0; t < 4; t++)
    begin
      slot_msg_type_i = t[1:0]; slot_tx_go_i = 1'b1;
      step();
      slot_tx_go_i = 1'b0;
      p = {7'h5B, 9'h1A5, 7'h55, 9'h0F3, t[1:0], 14'h2ABC};
      chk({slot_tx_err_o, slot_tx_valid_o}, {t == 3, t != 3}, "slot tx answer");
      if (t != 3)
        chk(dedicated_slot_packet_o, p, "slot packet");
      step();
    end
    for (int c = 0; c < 14; c++)
    begin
      p = {c[0], 6'h1B, 9'h1A5, 7'h55, 9'h0F3, c[3:2], 14'h2ABC};
      slot_rx_dir_i = c[1]; slot_rx_packet_i = p; slot_rx_valid_i = 1'b1;
      step();
      slot_rx_valid_i = 1'b0;
      chk({slot_rx_valid_o, slot_rx_seq_o, slot_rx_conn_o, slot_rx_len_o, slot_rx_pos_o, slot_rx_node_o},
        {1'b1, 5'h1B, 9'h1A5, 7'h55, 9'h0F3, 14'h2ABC}, "slot rx fields");
      case ({c[3:2], c[1]})
        3'h0: chk(slot_rx_kind_o, PMC_SLOT_ALLOC_REQ, "alloc req");
        3'h1: chk(slot_rx_kind_o, c[0] ? PMC_SLOT_ALLOC_GRANT : PMC_SLOT_ALLOC_REJECT, "grant");
        3'h2: chk(slot_rx_kind_o, PMC_SLOT_DEALLOC_REQ, "dealloc req");
        3'h3: chk(slot_rx_kind_o, PMC_SLOT_DEALLOC_CONFIRM, "dealloc rsp");
        3'h5: chk(slot_rx_kind_o, PMC_SLOT_RELOCATE, "relocate");
        default: chk(slot_rx_kind_o, PMC_SLOT_NONE, "no meaning");
      endcase
      step();
    end
  endtask : slot_test
  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial
  begin
    repeat (3000) @(posedge sys_clk_i);
    n_errors++;
    tally_and_finish();
  end
  // zero inputs, 4-cycle reset, then scenarios
  initial
  begin
    {is_base_i, is_switch_i, role_tx_go_i, role_tx_kind_i, role_tx_ident_i, role_tx_modulation_i, role_rx_valid_i,
      downlink_dir_bit_i, role_negative_flag_i, role_ack_flag_i, new_switch_ident_i, role_rx_node_i,
      role_rx_from_switch_i, layout_tx_go_i, layout_length_attribute_i, legacy_phy_flag_i, reserved_period_length_i,
      layout_effective_seq_i, beacon_valid_i, beacon_seq_i, slot_tx_go_i, slot_accept_flag_i, slot_direction_i,
      slot_effective_seq_i, slot_connection_ident_i, slot_length_symbols_i, slot_offset_symbols_i, slot_msg_type_i,
      slot_target_node_i, slot_rx_valid_i, slot_rx_dir_i, slot_rx_packet_i, pk_send, pk_bad} = '0;
    nrst_i = 1'b0;
    repeat (4) step();
    nrst_i = 1'b1;
    role_tx(1'b1, 3'h2, 8'h3C, 1'b0, 1'b0, 3'h4);
    role_tx(1'b1, 3'h2, 8'hFF, 1'b0, 1'b1, 3'h0);
    role_tx(1'b0, 3'h3, 8'hFE, 1'b0, 1'b0, 3'h1);
    role_tx(1'b1, 3'h4, 8'h10, 1'b1, 1'b0, 3'h3);
    role_tx(1'b1, 3'h4, 8'h10, 1'b0, 1'b1, 3'h0);
    role_tx(1'b0, 3'h5, 8'h22, 1'b0, 1'b0, 3'h2);
    role_tx(1'b1, 3'h6, 8'h05, 1'b0, 1'b0, 3'h6);
    role_tx(1'b0, 3'h1, 8'h07, 1'b0, 1'b0, 3'h0);
    role_tx(1'b1, 3'h1, 8'h07, 1'b0, 1'b1, 3'h0);
    role_rx(1'b1, 3'h0, 8'h12, 3'h1, 1'b1);
    role_rx(1'b0, 3'h0, 8'h13, 3'h1, 1'b0);
    role_rx(1'b1, 3'h1, 8'h12, 3'h3, 1'b0);
    role_rx(1'b1, 3'h3, 8'h12, 3'h4, 1'b0);
    role_rx(1'b1, 3'h2, 8'h12, 3'h5, 1'b0);
    role_rx(1'b1, 3'h6, 8'hFF, 3'h6, 1'b0);
    role_rx(1'b1, 3'h1, 8'hFF, 3'h0, 1'b0);
    layout_test();
    slot_test();
    tally_and_finish();
  end
endmodule : pmc_codec_test
